// file: pkg/qei_pkg.sv
// constants and types shared by the quadrature encoder interface
package qei_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned DIV_W       = 3;
  localparam int unsigned PRE_W       = 7;
  localparam int unsigned EVT_N       = 4;
  localparam int unsigned SYNC_STAGES = 2;
  // interrupt event bit positions
  localparam int unsigned EVT_INDEX   = 0;
  localparam int unsigned EVT_TIMER   = 1;
  localparam int unsigned EVT_DIR     = 2;
  localparam int unsigned EVT_ERROR   = 3;
  // reset values
  localparam logic [31:0] POS_RST     = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST   = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST   = 32'h0000_0000;
  localparam logic [31:0] SPEED_RST   = 32'h0000_0000;
  localparam logic [3:0]  EVT_RST     = 4'h0;
  localparam logic [6:0]  PRE_RST     = 7'h00;

  // last edge seen, for direction-change detection
  typedef enum logic [1:0] {
    QEI_LAST_NONE = 2'b00,
    QEI_LAST_A    = 2'b01,
    QEI_LAST_B    = 2'b11
  } qei_last_type;
endpackage : qei_pkg

// file: core/qei_sync.sv
// two-flop synchroniser with edge outputs for one encoder input
`timescale 1ns/1ps
`default_nettype none
module qei_sync
  import qei_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic raw_in,
  output logic      level,
  output logic      edge_seen,
  output logic      rise
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } qei_sync_type;

  qei_sync_type s_q;
  qei_sync_type s_d;

  // meta is only read by sync
  always_comb begin
    s_d      = s_q;
    s_d.meta = raw_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level     = s_q.sync;
  assign edge_seen = s_q.sync ^ s_q.prev;
  assign rise      = s_q.sync & ~s_q.prev;
endmodule // qei_sync
`default_nettype wire

// file: core/qei_prediv.sv
// velocity predivider: passes one edge in every 2^setting
`timescale 1ns/1ps
`default_nettype none
module qei_prediv
  import qei_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] setting,
  input  wire logic             edge_in,
  output logic                  edge_out
);
  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } qei_prediv_type;

  qei_prediv_type p_q;
  qei_prediv_type p_d;
  logic [PRE_W-1:0] limit;

  assign limit = PRE_W'((8'h01 << setting) - 8'h01);

  always_comb begin
    p_d = p_q;
    if (!run) begin
      p_d.cnt = PRE_RST;
    end else if (edge_in) begin
      p_d.cnt = (p_q.cnt >= limit) ? PRE_RST : p_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  assign edge_out = run & edge_in & (p_q.cnt >= limit);
endmodule // qei_prediv
`default_nettype wire

// file: core/qei_core.sv
// quadrature encoder interface: position, velocity and interrupts
//
// Behaviour
// - velocity has own enable; runs only while position tracking enabled
// - optional swap of phase inputs before decoding
// - quadrature mode decodes direction from which phase edges first
// - step-direction mode: A is step clock, B level gives direction
// - quadrature capture on A edges only or both channel edges
// - A leading B increments, B leading A decrements
// - rise and fall on one phase without other edge flags direction change
// - index mode clears position on index; decrement from zero loads maximum
// - max mode keeps position in zero..maximum, index ignored
// - velocity counts edges with same selection as position
// - period end copies count to speed, clears count
// - timer counts down, on zero flags event and reloads
// - edges per line two for A only, four for both
// - events for phase error, direction change, index, timer
// - each event masked, raw and masked status, clear; irq from unmasked
// - inputs reach decoder only when alternate function selected
// - predivider divides velocity edges by two to the setting
// - separate inverts for channel a, channel b and index
// - stall on halt freezes counting during debug halt
`timescale 1ns/1ps
`default_nettype none
module qei_core
  import qei_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              quad_channel_a,
  input  wire logic              quad_channel_b,
  input  wire logic              index_pulse_input,
  input  wire logic              alt_function_sel,
  input  wire logic              position_enable,
  input  wire logic              velocity_enable,
  input  wire logic              swap_enable,
  input  wire logic              signal_interpretation_select,
  input  wire logic              edge_selection_setting,
  input  wire logic              position_reset_select,
  input  wire logic [DIV_W-1:0]  velocity_predivider_setting,
  input  wire logic              channel_a_invert,
  input  wire logic              channel_b_invert,
  input  wire logic              index_invert,
  input  wire logic              stall_on_halt,
  input  wire logic              debug_halt,
  input  wire logic [DATA_W-1:0] maximum_position,
  input  wire logic [DATA_W-1:0] velocity_timer_load,
  input  wire logic              position_write,
  input  wire logic [DATA_W-1:0] position_write_data,
  input  wire logic [EVT_N-1:0]  event_mask,
  input  wire logic [EVT_N-1:0]  event_clear,
  output logic [DATA_W-1:0]      position_value,
  output logic [DATA_W-1:0]      velocity_timer_value,
  output logic [DATA_W-1:0]      running_edge_count,
  output logic [DATA_W-1:0]      speed_result,
  output logic                   direction,
  output logic                   phase_error,
  output logic [EVT_N-1:0]       raw_status,
  output logic [EVT_N-1:0]       masked_status,
  output logic                   interrupt
);
  typedef struct packed {
    logic [DATA_W-1:0] pos;
    logic [DATA_W-1:0] timer;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] speed;
    logic [EVT_N-1:0]  raw;
    logic              dir;
    logic              err;
    qei_last_type      last;
    logic              last_rise;
  } qei_state_type;

  qei_state_type st_q;
  qei_state_type st_d;

  logic gated_a, gated_b, gated_i;
  logic a_lvl, b_lvl;
  logic a_edge, b_edge, a_rise, b_rise, i_rise;
  logic [2:0] gated_vec;
  logic [2:0] lvl_vec;
  logic [2:0] edge_vec;
  logic [2:0] rise_vec;
  logic ph_a, ph_b, e_a, e_b;
  logic frozen, pos_run, vel_run;
  logic step, up, vel_edge, both_edges, dir_flip;
  logic [EVT_N-1:0] evt;

  // pins stay with the general-purpose port until selected
  assign gated_a = alt_function_sel
                   & (quad_channel_a ^ channel_a_invert);
  assign gated_b = alt_function_sel
                   & (quad_channel_b ^ channel_b_invert);
  assign gated_i = alt_function_sel
                   & (index_pulse_input ^ index_invert);
  assign gated_vec = {gated_i, gated_b, gated_a};

  // one synchroniser per pin: bit 0 a, bit 1 b, bit 2 index
  for (genvar g = 0; g < 3; g++) begin : g_sync
    qei_sync u_sync (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .raw_in    (gated_vec[g]),
      .level     (lvl_vec[g]),
      .edge_seen (edge_vec[g]),
      .rise      (rise_vec[g])
    );
  end
  assign a_lvl  = lvl_vec[0];
  assign b_lvl  = lvl_vec[1];
  assign a_edge = edge_vec[0];
  assign b_edge = edge_vec[1];
  assign a_rise = rise_vec[0];
  assign b_rise = rise_vec[1];
  assign i_rise = rise_vec[2];

  // swap after sync so both paths see equal latency
  assign ph_a = swap_enable ? b_lvl : a_lvl;
  assign ph_b = swap_enable ? a_lvl : b_lvl;
  assign e_a  = swap_enable ? b_edge : a_edge;
  assign e_b  = swap_enable ? a_edge : b_edge;
  assign both_edges = e_a & e_b;

  assign frozen  = stall_on_halt & debug_halt;
  assign pos_run = position_enable & ~frozen;
  assign vel_run = pos_run & velocity_enable;

  always_comb begin
    step = 1'b0;
    up   = 1'b1;
    if (signal_interpretation_select) begin
      // step on rising step clock, level of other input is direction
      step = swap_enable ? b_rise : a_rise;
      up   = ~ph_b;
    end else begin
      // a changed: a leads when a now differs from b
      if (e_a && !e_b) begin
        step = 1'b1;
        up   = ph_a ^ ph_b;
      end else if (e_b && !e_a && edge_selection_setting) begin
        step = 1'b1;
        up   = ~(ph_a ^ ph_b);
      end
    end
  end

  // rise then fall on one phase with nothing on the other
  assign dir_flip = ~signal_interpretation_select & ~both_edges &
                    ((e_a && st_q.last == QEI_LAST_A) ||
                     (e_b && st_q.last == QEI_LAST_B));

  qei_prediv u_prediv (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (vel_run),
    .setting  (velocity_predivider_setting),
    .edge_in  (step),
    .edge_out (vel_edge)
  );

  always_comb begin
    st_d = st_q;
    evt  = EVT_RST;
    if (pos_run) begin
      if (!signal_interpretation_select) begin
        if (both_edges) begin
          st_d.err = 1'b1;
          evt[EVT_ERROR] = 1'b1;
        end
        if (e_a && !e_b) begin
          st_d.last = QEI_LAST_A;
        end else if (e_b && !e_a) begin
          st_d.last = QEI_LAST_B;
        end
        if (dir_flip) begin
          evt[EVT_DIR] = 1'b1;
        end
      end
      if (step) begin
        st_d.dir = ~up;
        if (up) begin
          st_d.pos = (st_q.pos >= maximum_position) ? POS_RST
                     : st_q.pos + 32'h0000_0001;
        end else begin
          st_d.pos = (st_q.pos == POS_RST || st_q.pos > maximum_position)
                     ? maximum_position : st_q.pos - 32'h0000_0001;
        end
      end
      if (i_rise) begin
        evt[EVT_INDEX] = 1'b1;
        if (position_reset_select) begin
          st_d.pos = POS_RST;
        end
      end
    end
    if (position_write) begin
      st_d.pos = position_write_data;
    end
    if (vel_run) begin
      if (st_q.timer == TIMER_RST) begin
        st_d.timer = velocity_timer_load;
        st_d.speed = st_q.count + {31'h0000_0000, vel_edge};
        st_d.count = COUNT_RST;
        evt[EVT_TIMER] = 1'b1;
      end else begin
        st_d.timer = st_q.timer - 32'h0000_0001;
        st_d.count = st_q.count + {31'h0000_0000, vel_edge};
      end
    end else if (!velocity_enable) begin
      st_d.timer = velocity_timer_load;
      st_d.count = COUNT_RST;
    end
    // a new event wins over a clear in the same cycle
    st_d.raw = (st_q.raw & ~event_clear) | evt;
    if (event_clear[EVT_ERROR] && !evt[EVT_ERROR]) begin
      st_d.err = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign position_value       = st_q.pos;
  assign velocity_timer_value = st_q.timer;
  assign running_edge_count   = st_q.count;
  assign speed_result         = st_q.speed;
  assign direction            = st_q.dir;
  assign phase_error          = st_q.err;
  assign raw_status           = st_q.raw;
  assign masked_status        = st_q.raw & event_mask;
  assign interrupt            = |masked_status;

  // checks
  property p_timer_reload;
    @(posedge core_clk) disable iff (!arst_n)
      (vel_run && st_q.timer == TIMER_RST) |=>
        (st_q.raw[EVT_TIMER] && st_q.count == COUNT_RST);
  endproperty
  timer_reload_a : assert property (p_timer_reload)
    else $error("timer expiry did not flag and clear count");

  speed_capture_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (vel_run && st_q.timer == TIMER_RST && !vel_edge) |=>
      st_q.speed == $past(st_q.count))
    else $error("speed not loaded from running count");

  index_clear_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (pos_run && i_rise && position_reset_select && !position_write) |=>
      st_q.pos == POS_RST)
    else $error("index did not clear position");

  pos_range_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (pos_run && step && !i_rise && !position_write
     && st_q.pos <= maximum_position) |=>
      st_q.pos <= $past(maximum_position))
    else $error("position left zero to maximum range");

  wrap_down_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (pos_run && step && !up && st_q.pos == POS_RST && !i_rise
     && !position_write) |=> st_q.pos == $past(maximum_position))
    else $error("decrement from zero did not load maximum");

  vel_gate_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !position_enable |=> $stable(st_q.speed))
    else $error("velocity ran without position tracking");

  stall_hold_a : assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (frozen && !position_write) |=> $stable(st_q.pos))
    else $error("position moved during halt stall");

  sequence s_a_only;
    pos_run && !signal_interpretation_select && e_a && !e_b;
  endsequence
  sequence s_b_ignored;
    pos_run && !signal_interpretation_select && !edge_selection_setting
    && e_b && !e_a && !i_rise && !position_write;
  endsequence
  a_step_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    s_a_only |-> step)
    else $error("channel a edge not counted");
  b_skip_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    s_b_ignored |=> $stable(st_q.pos))
    else $error("channel b edge counted in a-only mode");

  irq_mask_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    interrupt |-> |(st_q.raw & event_mask))
    else $error("interrupt without unmasked pending event");

  dir_event_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (pos_run && !signal_interpretation_select && e_a && !e_b
     && st_q.last == QEI_LAST_A) |=> st_q.raw[EVT_DIR])
    else $error("repeated a edge did not flag direction change");

  phase_err_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (pos_run && !signal_interpretation_select && e_a && e_b && !i_rise
     && !position_write) |=> (st_q.err && st_q.raw[EVT_ERROR]
     && $stable(st_q.pos)))
    else $error("simultaneous phase edges not flagged as error");

  index_event_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (pos_run && i_rise) |=> st_q.raw[EVT_INDEX])
    else $error("index pulse did not raise its event");

  index_ignore_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (pos_run && i_rise && !position_reset_select && !step
     && !position_write) |=> $stable(st_q.pos))
    else $error("index moved position in maximum mode");

  // four low samples flush both synchroniser stages and the edge flop
  gpio_block_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    !alt_function_sel [*4] |-> !(a_edge || b_edge || i_rise))
    else $error("encoder edge seen while pins are general purpose");

  vel_count_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (vel_run && st_q.timer != TIMER_RST && vel_edge) |=>
      st_q.count == $past(st_q.count) + 32'h0000_0001)
    else $error("divided edge not added to running count");

  irq_hold_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    (interrupt && event_clear == EVT_RST) ##1 $stable(event_mask)
      |-> interrupt)
    else $error("pending unmasked event lost without a clear");

  sequence s_step_up;
    pos_run && signal_interpretation_select && step && !ph_b && !i_rise
    && !position_write && st_q.pos < maximum_position;
  endsequence
  step_up_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    s_step_up |=> st_q.pos == $past(st_q.pos) + 32'h0000_0001)
    else $error("step with direction low did not count up");

  sequence s_a_leads;
    pos_run && !signal_interpretation_select && e_a && !e_b
    && ph_a != ph_b && !i_rise && !position_write
    && st_q.pos < maximum_position;
  endsequence
  count_up_a : assert property (@(posedge core_clk) disable iff (!arst_n)
    s_a_leads |=> st_q.pos == $past(st_q.pos) + 32'h0000_0001)
    else $error("a edge leading b did not count up");
endmodule // qei_core
`default_nettype wire

// file: test/qei_encoder_model.sv
// behavioural incremental encoder driving the phase and index pins
`timescale 1ns/1ps
`default_nettype none
module qei_encoder_model (
  input  wire logic core_clk,
  output logic      pin_a,
  output logic      pin_b,
  output logic      pin_idx
);
  logic [1:0] st;
  initial begin
    st      = 2'h0;
    pin_a   = 1'b0;
    pin_b   = 1'b0;
    pin_idx = 1'b0;
  end
  // each level held 5 cycles so edges stay below a quarter of the clock
  task automatic set_pins(input logic a, input logic b);
    @(negedge core_clk);
    pin_a = a;
    pin_b = b;
    repeat (4) @(negedge core_clk);
  endtask
  // gray order 00,10,11,01 going forward: a leads b by a quarter cycle
  task automatic step(input logic fwd);
    st = fwd ? st + 2'h1 : st - 2'h1;
    set_pins(st[0] ^ st[1], st[1]);
  endtask
  task automatic index_pulse();
    @(negedge core_clk);
    pin_idx = 1'b1;
    repeat (4) @(negedge core_clk);
    pin_idx = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
endmodule // qei_encoder_model
`default_nettype wire

// file: test/qei_core_test.sv
// self-checking bench for the quadrature encoder interface
`timescale 1ns/1ps
`default_nettype none
module qei_core_test;
  import qei_pkg::*;
  logic              core_clk, arst_n, ea, eb, ei, alt, pos_en, vel_en;
  logic              swap, sig, esel, rsel, inv_a, inv_b, inv_i, stall, halt;
  logic [DIV_W-1:0]  prediv;
  logic [DATA_W-1:0] max_pos, load, pos, tmr, cnt, spd;
  logic [EVT_N-1:0]  mask, clr, raw, msk;
  logic              dir, perr, irq, pwr;
  logic [DATA_W-1:0] pwd;
  int                error_cnt, num_checks;

  qei_encoder_model enc (.core_clk(core_clk), .pin_a(ea), .pin_b(eb),
    .pin_idx(ei));
  qei_core dut (.core_clk(core_clk), .arst_n(arst_n), .quad_channel_a(ea),
    .quad_channel_b(eb), .index_pulse_input(ei), .alt_function_sel(alt),
    .position_enable(pos_en), .velocity_enable(vel_en),
    .swap_enable(swap), .signal_interpretation_select(sig),
    .edge_selection_setting(esel), .position_reset_select(rsel),
    .velocity_predivider_setting(prediv), .channel_a_invert(inv_a),
    .channel_b_invert(inv_b), .index_invert(inv_i),
    .stall_on_halt(stall), .debug_halt(halt), .maximum_position(max_pos),
    .velocity_timer_load(load), .position_write(pwr),
    .position_write_data(pwd), .event_mask(mask),
    .event_clear(clr), .position_value(pos), .velocity_timer_value(tmr),
    .running_edge_count(cnt), .speed_result(spd), .direction(dir),
    .phase_error(perr), .raw_status(raw), .masked_status(msk),
    .interrupt(irq));

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input logic fwd, input int n);
    repeat (n) enc.step(fwd);
  endtask
  task automatic clear_evt(input logic [EVT_N-1:0] m);
    @(negedge core_clk);
    clr = m;
    @(negedge core_clk);
    clr = 4'h0;
  endtask
  // bounded wait: a dead timer must not hang the run
  task automatic wait_evt(input int b);
    int k;
    for (k = 0; k < 600 && raw[b] !== 1'b1; k++) @(negedge core_clk);
    check("timer event", raw[b], 32'h0000_0001);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {arst_n, alt, pos_en, vel_en, swap, sig, esel, rsel} = 8'h00;
    {inv_a, inv_b, inv_i, stall, halt} = 5'h00;
    prediv = 3'h0;
    max_pos = 32'h0000_0007;
    load = 32'h0000_0190;
    mask = 4'h0;
    clr = 4'h0;
    pwr = 1'b0;
    pwd = 32'h0000_0000;
    error_cnt = 0;
    num_checks = 0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    check("pos reset", pos, 32'h0000_0000);
    check("speed reset", spd, 32'h0000_0000);
    check("raw reset", raw, 32'h0000_0000);
    {alt, pos_en, esel} = 3'h7;
    run(1'b0, 4);
    check("pos down wrap", pos, 32'h0000_0004);
    check("direction down", dir, 32'h0000_0001);
    run(1'b1, 4);
    check("pos up wrap", pos, 32'h0000_0000);
    esel = 1'b0;
    run(1'b1, 4);
    check("pos a only", pos, 32'h0000_0002);
    esel = 1'b1;
    enc.index_pulse();
    check("pos index ignored", pos, 32'h0000_0002);
    check("index event", raw[EVT_INDEX], 32'h0000_0001);
    rsel = 1'b1;
    enc.index_pulse();
    check("pos index clear", pos, 32'h0000_0000);
    run(1'b0, 1);
    check("pos below zero", pos, 32'h0000_0007);
    run(1'b1, 1);
    rsel = 1'b0;
    clear_evt(4'hf);
    run(1'b1, 1);
    run(1'b0, 1);
    check("dir change", raw[EVT_DIR], 32'h0000_0001);
    check("irq masked", irq, 32'h0000_0000);
    mask = 4'h4;
    @(negedge core_clk);
    check("masked status", msk, 32'h0000_0004);
    check("irq unmasked", irq, 32'h0000_0001);
    clear_evt(4'h4);
    check("irq cleared", irq, 32'h0000_0000);
    swap = 1'b1;
    run(1'b1, 4);
    check("pos swapped", pos, 32'h0000_0004);
    swap = 1'b0;
    alt = 1'b0;
    run(1'b1, 4);
    check("pos gpio", pos, 32'h0000_0004);
    alt = 1'b1;
    {stall, halt} = 2'h3;
    run(1'b1, 4);
    check("pos stalled", pos, 32'h0000_0004);
    {stall, halt} = 2'h0;
    sig = 1'b1;
    repeat (3) begin
      enc.set_pins(1'b1, 1'b0);
      enc.set_pins(1'b0, 1'b0);
    end
    check("step up", pos, 32'h0000_0007);
    enc.set_pins(1'b0, 1'b1);
    repeat (2) begin
      enc.set_pins(1'b1, 1'b1);
      enc.set_pins(1'b0, 1'b1);
    end
    enc.set_pins(1'b0, 1'b0);
    check("step down", pos, 32'h0000_0005);
    swap = 1'b1;
    enc.set_pins(1'b0, 1'b1);
    check("step swapped up", pos, 32'h0000_0006);
    enc.set_pins(1'b1, 1'b0);
    enc.set_pins(1'b1, 1'b1);
    enc.set_pins(1'b0, 1'b0);
    check("step swapped down", pos, 32'h0000_0005);
    swap = 1'b0;
    sig = 1'b0;
    clear_evt(4'hf);
    {inv_a, inv_b} = 2'h3;
    repeat (5) @(negedge core_clk);
    check("phase error", perr, 32'h0000_0001);
    check("error event", raw[EVT_ERROR], 32'h0000_0001);
    check("pos on error", pos, 32'h0000_0005);
    {inv_a, inv_b} = 2'h0;
    repeat (5) @(negedge core_clk);
    clear_evt(4'hf);
    check("error cleared", perr, 32'h0000_0000);
    prediv = 3'h2;
    vel_en = 1'b1;
    run(1'b1, 8);
    check("pos full turn", pos, 32'h0000_0005);
    check("count prediv", cnt, 32'h0000_0002);
    wait_evt(EVT_TIMER);
    @(negedge core_clk);
    check("speed", spd, 32'h0000_0002);
    check("timer reload", tmr, 32'h0000_018F);
    check("count cleared", cnt, 32'h0000_0000);
    clear_evt(4'hf);
    wait_evt(EVT_TIMER);
    @(negedge core_clk);
    check("speed idle", spd, 32'h0000_0000);
    pwd = 32'h0000_0009;
    pwr = 1'b1;
    @(negedge core_clk);
    pwr = 1'b0;
    check("pos written", pos, 32'h0000_0009);
    enc.step(1'b1);
    check("pos wrap from above", pos, 32'h0000_0000);
    print_verdict();
  end
endmodule // qei_core_test
`default_nettype wire
